// ===== hdl/ms_tick.sv
// Millisecond tick divider with a free-running millisecond count.
// Assumes one system clock; the count wraps after 2^32 ms.
`timescale 1ns/10ps
`default_nettype none
module ms_tick #(
	parameter int TICK_CYCLES = 125000
) (
	input wire logic clk,
	input wire logic rst_n,
	output logic tick,
	output logic [31:0] ms_count
);
	logic [31:0] div_reg;

	// Divide the clock down to a one-cycle pulse each millisecond.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 32'h0;
			tick <= 1'b0;
			ms_count <= 32'h0;
		end else begin
			tick <= (div_reg == 32'(TICK_CYCLES - 1));
			if (div_reg == 32'(TICK_CYCLES - 1)) begin
				div_reg <= 32'h0;
				ms_count <= ms_count + 32'h1;
			end else begin
				div_reg <= div_reg + 32'h1;
			end
		end
	end
endmodule // ms_tick
`default_nettype wire

// ===== hdl/stat_service.sv
// Status indicator, service access and operating mode control.
// Assumes radio events arrive on SYS_CLK; SERVICE_N and TXD_IN are pins.
`timescale 1ns/10ps
`default_nettype none
module stat_service #(
	parameter int TICK_CYCLES = stat_service_pkg::TICK_CYCLES_DEF
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic SERVICE_N,
	input wire logic TXD_IN,
	input wire logic RF_SYNC_FOUND,
	input wire logic RF_FRAME_ACTIVE,
	input wire logic TX_REQ,
	input wire logic TX_FRAME_START,
	input wire logic FAULT_EVENT,
	input wire logic [7:0] FAULT_CODE_IN,
	input wire logic ESCAPE_SEQ,
	output logic STAT,
	output logic [31:0] SER_CFG,
	output logic SERVICE_MODE,
	output logic CMD_SET_EN,
	output logic RADIO_RX_EN,
	output logic RADIO_TX_EN,
	output logic WAKE_ACK,
	output logic REBOOT,
	output logic IRQ
);
	import stat_service_pkg::*;

	// Merge written bytes into an old word.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// True on a millisecond boundary that is a whole number of intervals.
	function automatic logic hit(input logic [31:0] cnt,
		input logic [31:0] n);
		return (cnt % n) == 32'h0;
	endfunction

	logic tick;
	logic [31:0] ms_now;
	logic svc_meta, svc_sync, svc_prev, txd_meta, txd_sync, txd_ref;
	logic aw_full, w_full, do_wr;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [5:0] ctrl_reg;
	logic [31:0] sercfg_reg;
	logic [7:0] fcode_reg;
	logic [IRQ_BITS-1:0] int_stat_reg, int_en_reg, int_clr, events;
	logic cmd_mode_reg;
	mode_t mode_reg;
	logic [15:0] reboot_cnt;
	logic [10:0] wake_cnt;
	logic frame_prev, frame_end, frame_start, sleep_req, restart;
	logic ps_sleep, ps_have_last;
	logic [2:0] ps_pkts;
	logic [6:0] ps_cycles;
	logic [15:0] ps_tmin, ps_left, ps_marg;
	logic [31:0] ps_last, ps_since;
	logic blocked;

	// Divider for the millisecond time base.
	ms_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.tick(tick),
		.ms_count(ms_now)
	);

	// Pin inputs pass two flip-flops before any logic sees them.
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			svc_meta <= 1'b1;
			svc_sync <= 1'b1;
			svc_prev <= 1'b1;
			txd_meta <= 1'b1;
			txd_sync <= 1'b1;
		end else begin
			svc_meta <= SERVICE_N;
			svc_sync <= svc_meta;
			svc_prev <= svc_sync;
			txd_meta <= TXD_IN;
			txd_sync <= txd_meta;
		end
	end

	// Write side of the bus: address and data are taken in either order.
	assign S_AXI_AWREADY = !aw_full && !S_AXI_BVALID;
	assign S_AXI_WREADY = !w_full && !S_AXI_BVALID;
	assign do_wr = aw_full && w_full && !S_AXI_BVALID;
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 8'h0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= 2'h0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_full <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_full <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
			if (do_wr) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				unique case ({aw_addr[7:2], 2'b00})
					CTRL_OFS, SERCFG_OFS, INT_EN_OFS, INT_CLR_OFS:
						S_AXI_BRESP <= 2'h0;
					default: S_AXI_BRESP <= 2'h2;
				endcase
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// One-cycle write effects decoded from the pending write.
	assign sleep_req = do_wr && aw_addr[7:2] == CTRL_OFS[7:2] &&
		w_strb[0] && w_data[CTRL_SLEEP];
	assign restart = do_wr && aw_addr[7:2] == CTRL_OFS[7:2] &&
		w_strb[0] && w_data[CTRL_RESTART];
	assign int_clr = (do_wr && aw_addr[7:2] == INT_CLR_OFS[7:2] &&
		w_strb[0]) ? w_data[IRQ_BITS-1:0] : '0;

	// Stored settings; the service input never touches them.
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_reg <= 6'h0;
			sercfg_reg <= SERCFG_RESET;
			int_en_reg <= '0;
		end else if (do_wr) begin
			if (aw_addr[7:2] == CTRL_OFS[7:2] && w_strb[0]) begin
				ctrl_reg[CTRL_CMD_EN] <= w_data[CTRL_CMD_EN];
				ctrl_reg[CTRL_TOOL] <= w_data[CTRL_TOOL];
				ctrl_reg[CTRL_PSAVE] <= w_data[CTRL_PSAVE];
			end
			if (aw_addr[7:2] == SERCFG_OFS[7:2]) begin
				sercfg_reg <= merge(sercfg_reg, w_data, w_strb);
			end
			if (aw_addr[7:2] == INT_EN_OFS[7:2] && w_strb[0]) begin
				int_en_reg <= w_data[IRQ_BITS-1:0];
			end
		end
	end

	// Read side of the bus; answer comes at the edge that takes the address.
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0;
			S_AXI_RRESP <= 2'h0;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RRESP <= 2'h0;
			unique case ({S_AXI_ARADDR[7:2], 2'b00})
				CTRL_OFS: S_AXI_RDATA <= {26'h0, ctrl_reg};
				SERCFG_OFS: S_AXI_RDATA <= sercfg_reg;
				STATUS_OFS: S_AXI_RDATA <= {20'h0, 1'b0, ps_pkts,
					STAT, ps_sleep, cmd_mode_reg, CMD_SET_EN,
					SERVICE_MODE, mode_reg};
				FCODE_OFS: S_AXI_RDATA <= {24'h0, fcode_reg};
				INT_STAT_OFS: S_AXI_RDATA <= 32'(int_stat_reg);
				INT_EN_OFS: S_AXI_RDATA <= 32'(int_en_reg);
				MS_CNT_OFS: S_AXI_RDATA <= ms_now;
				default: begin
					S_AXI_RDATA <= 32'h0;
					S_AXI_RRESP <= 2'h2;
				end
			endcase
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// Service access: the port setting swaps only while the pin is low.
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			SER_CFG <= SERCFG_RESET;
			SERVICE_MODE <= 1'b0;
			CMD_SET_EN <= 1'b0;
		end else begin
			SERVICE_MODE <= !svc_sync;
			SER_CFG <= svc_sync ? sercfg_reg : SERCFG_SERVICE;
			CMD_SET_EN <= !svc_sync || ctrl_reg[CTRL_CMD_EN] ||
				cmd_mode_reg;
		end
	end

	// Escape-entered command mode; a new escape beats an exit request.
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cmd_mode_reg <= 1'b0;
		end else if (ESCAPE_SEQ && !ctrl_reg[CTRL_CMD_EN]) begin
			cmd_mode_reg <= 1'b1;
		end else if (do_wr && aw_addr[7:2] == CTRL_OFS[7:2] &&
			w_strb[0] && w_data[CTRL_CMD_EXIT]) begin
			cmd_mode_reg <= 1'b0;
		end
	end

	// Frame edges seen by the receiver.
	assign frame_start = RF_FRAME_ACTIVE && !frame_prev;
	assign frame_end = !RF_FRAME_ACTIVE && frame_prev;
	assign blocked = mode_reg == M_FAULT || mode_reg == M_SAFE;

	// Operating mode sequencer.
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mode_reg <= M_SEARCH;
			frame_prev <= 1'b0;
			reboot_cnt <= 16'h0;
			wake_cnt <= 11'h0;
			txd_ref <= 1'b1;
			fcode_reg <= 8'h0;
			WAKE_ACK <= 1'b0;
			REBOOT <= 1'b0;
		end else begin
			frame_prev <= RF_FRAME_ACTIVE;
			WAKE_ACK <= 1'b0;
			REBOOT <= 1'b0;
			if (FAULT_EVENT && !blocked) begin
				mode_reg <= M_FAULT;
				fcode_reg <= FAULT_CODE_IN;
				reboot_cnt <= 16'h0;
			end else begin
				unique case (mode_reg)
					M_SEARCH: begin
						if (sleep_req) begin
							mode_reg <= M_SLEEP;
							txd_ref <= txd_sync;
							wake_cnt <= 11'h0;
						end else if (TX_REQ) begin
							mode_reg <= M_TX;
						end else if (RF_SYNC_FOUND && !ps_sleep) begin
							mode_reg <= M_RECEIVE;
						end
					end
					M_RECEIVE: begin
						if (sleep_req) begin
							mode_reg <= M_SLEEP;
							txd_ref <= txd_sync;
							wake_cnt <= 11'h0;
						end else if (frame_end) begin
							mode_reg <= M_SEARCH;
						end
					end
					M_TX: begin
						if (!TX_REQ) begin
							mode_reg <= M_SEARCH;
						end
					end
					M_FAULT: begin
						if (tick) begin
							reboot_cnt <= reboot_cnt + 16'h1;
						end
						if (reboot_cnt == REBOOT_MS) begin
							REBOOT <= 1'b1;
							mode_reg <= M_SAFE;
						end
					end
					M_SAFE: begin
						if (restart) begin
							mode_reg <= M_SEARCH;
						end
					end
					M_SLEEP: begin
						// A glitch shorter than the minimum restarts the count.
						if (txd_sync == txd_ref) begin
							wake_cnt <= 11'h0;
						end else if (wake_cnt == 11'(WAKE_CYCLES - 1)) begin
							WAKE_ACK <= 1'b1;
							mode_reg <= M_SEARCH;
						end else begin
							wake_cnt <= wake_cnt + 11'h1;
						end
					end
				endcase
			end
		end
	end

	// Radio enables: nothing moves during a fault or in safe mode.
	assign RADIO_TX_EN = mode_reg == M_TX;
	assign RADIO_RX_EN = (mode_reg == M_SEARCH ||
		mode_reg == M_RECEIVE) && !ps_sleep;

	// Power save study: shortest gap, frame length, then sleep windows.
	// Widths limit gaps to 65 s, far beyond any practical packet rate.
	assign ps_marg = (ps_tmin >> 3) + PS_MARGIN_MS;
	assign ps_since = ms_now - ps_last;
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ps_sleep <= 1'b0;
			ps_have_last <= 1'b0;
			ps_pkts <= 3'h0;
			ps_cycles <= 7'h0;
			ps_tmin <= 16'hffff;
			ps_left <= 16'h0;
			ps_last <= 32'h0;
		end else if (!ctrl_reg[CTRL_PSAVE] || mode_reg != M_SEARCH &&
			mode_reg != M_RECEIVE) begin
			ps_sleep <= 1'b0;
			ps_have_last <= 1'b0;
			ps_pkts <= 3'h0;
			ps_cycles <= 7'h0;
			ps_tmin <= 16'hffff;
		end else if (ps_sleep) begin
			if (tick) begin
				ps_left <= ps_left - 16'h1;
				ps_sleep <= ps_left > 16'h1;
			end
		end else if (frame_start) begin
			ps_last <= ms_now;
			ps_have_last <= 1'b1;
			if (ps_have_last && ps_since[15:0] < ps_tmin) begin
				ps_tmin <= ps_since[15:0];
			end
			if (ps_have_last && ps_pkts != PS_STUDY_PKTS) begin
				ps_pkts <= ps_pkts + 3'h1;
			end
		end else if (frame_end) begin
			// The frame just ended gives the transmission time directly.
			if (ps_pkts == PS_STUDY_PKTS &&
				ps_tmin > ps_marg + ps_since[15:0]) begin
				ps_sleep <= 1'b1;
				ps_left <= ps_tmin - ps_marg - ps_since[15:0];
				ps_cycles <= ps_cycles + 7'h1;
			end
		end else if (ps_pkts == PS_STUDY_PKTS &&
			(ps_cycles == PS_CYCLES || ps_since >
			32'(ps_tmin + ps_marg + PS_OVERLAP_MS))) begin
			// Restart the study after a run of cycles or a lost packet.
			ps_pkts <= 3'h0;
			ps_cycles <= 7'h0;
			ps_have_last <= 1'b0;
			ps_tmin <= 16'hffff;
		end
	end

	// Status indicator patterns in fixed precedence.
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			STAT <= STAT_RESET;
		end else if (blocked) begin
			if (tick && hit(ms_now, FAULT_MS)) begin
				STAT <= !STAT;
			end
		end else if (cmd_mode_reg) begin
			if (tick && hit(ms_now, CMD_MS)) begin
				STAT <= !STAT;
			end
		end else if (ctrl_reg[CTRL_TOOL]) begin
			if (tick && hit(ms_now, TOOL_MS)) begin
				STAT <= !STAT;
			end
		end else if (mode_reg == M_TX) begin
			if (TX_FRAME_START) begin
				STAT <= !STAT;
			end
		end else if (mode_reg == M_SLEEP) begin
			STAT <= 1'b0;
		end else begin
			STAT <= !RF_FRAME_ACTIVE;
		end
	end

	// Sticky interrupt status; an event in the clearing cycle survives.
	assign events = {ESCAPE_SEQ && !ctrl_reg[CTRL_CMD_EN],
		svc_sync != svc_prev, WAKE_ACK,
		frame_end, FAULT_EVENT && !blocked};
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			int_stat_reg <= '0;
		end else begin
			int_stat_reg <= (int_stat_reg & ~int_clr) | events;
		end
	end
	assign IRQ = |(int_stat_reg & int_en_reg);
endmodule // stat_service
`default_nettype wire

// ===== hdl/stat_service_pkg.sv
// Constants shared by the status indicator and service mode block.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
package stat_service_pkg;
	// Register byte offsets.
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] SERCFG_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] FCODE_OFS = 8'h0c;
	localparam logic [7:0] INT_STAT_OFS = 8'h10;
	localparam logic [7:0] INT_EN_OFS = 8'h14;
	localparam logic [7:0] INT_CLR_OFS = 8'h18;
	localparam logic [7:0] MS_CNT_OFS = 8'h1c;
	// Control register field positions.
	localparam int CTRL_CMD_EN = 0;
	localparam int CTRL_TOOL = 1;
	localparam int CTRL_SLEEP = 2;
	localparam int CTRL_PSAVE = 3;
	localparam int CTRL_RESTART = 4;
	localparam int CTRL_CMD_EXIT = 5;
	// Serial setting fields: [19:0] baud, [23:20] data bits,
	// [25:24] parity (0 none), [26] two stop bits.
	localparam logic [31:0] SERCFG_RESET = 32'h0080_2580;
	localparam logic [31:0] SERCFG_SERVICE = 32'h0080_9600;
	// Interrupt bit positions.
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_FRAME = 1;
	localparam int IRQ_WAKE = 2;
	localparam int IRQ_SVC = 3;
	localparam int IRQ_ESC = 4;
	localparam int IRQ_BITS = 5;
	// Times and their cycle counts.
	localparam int CLK_PERIOD_NS = 8;
	localparam int WAKE_MIN_NS = 10000;
	localparam int WAKE_CYCLES =
		(WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES_DEF = TICK_MS * 1000000 / CLK_PERIOD_NS;
	localparam logic [31:0] FAULT_MS = 32'd250;
	localparam logic [31:0] CMD_MS = 32'd500;
	localparam logic [31:0] TOOL_MS = 32'd1000;
	localparam logic [15:0] REBOOT_MS = 16'd5000;
	localparam logic [15:0] PS_MARGIN_MS = 16'd60;
	localparam logic [15:0] PS_OVERLAP_MS = 16'd100;
	localparam logic [2:0] PS_STUDY_PKTS = 3'd4;
	localparam logic [6:0] PS_CYCLES = 7'd100;
	localparam logic STAT_RESET = 1'b1;
	typedef enum logic [2:0] {
		M_SEARCH, M_RECEIVE, M_TX, M_FAULT, M_SAFE, M_SLEEP
	} mode_t;
endpackage

// ===== verification/host_model.sv
// Host terminal model: drives the service pin and the transmit data pin.
// Assumes the bench asks for service access and wake-up by levels.
`timescale 1ns/10ps
`default_nettype none
module host_model #(
	parameter int HOLD = 1300
) (
	input wire logic clk,
	input wire logic svc_on,
	input wire logic wake_go,
	output logic service_n,
	output logic txd
);
	logic go_q = 1'b0;
	int cnt = 0;
	// A wake request holds the line low a little past the minimum width.
	always_ff @(posedge clk) begin
		go_q <= wake_go;
		if (wake_go && !go_q)
			cnt <= HOLD;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
	// Released pins sit at the pulled-up idle level, never floating.
	assign txd = (cnt != 0) ? 1'b0 : 1'b1;
	assign service_n = svc_on ? 1'b0 : 1'b1;
endmodule // host_model
`default_nettype wire

// ===== verification/stat_service_chk.sv
// Port checker for the status and service block, bound to stat_service.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module stat_service_chk (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic SERVICE_N,
	input wire logic TXD_IN,
	input wire logic [31:0] SER_CFG,
	input wire logic SERVICE_MODE,
	input wire logic CMD_SET_EN,
	input wire logic RADIO_RX_EN,
	input wire logic RADIO_TX_EN,
	input wire logic WAKE_ACK,
	input wire logic REBOOT
);
	import stat_service_pkg::*;
	logic txd_q;
	logic [11:0] run_cnt;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	// Edges since the transmit data pin last moved; a wake needs a long run.
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			txd_q <= 1'b1;
			run_cnt <= '0;
		end else begin
			txd_q <= TXD_IN;
			if (TXD_IN != txd_q)
				run_cnt <= '0;
			else if (run_cnt != 12'hfff)
				run_cnt <= run_cnt + 12'h001;
		end
	end
	// Four edges cover the two sync stages and the output register.
	sequence svc_low_s;
		!SERVICE_N [*4];
	endsequence
	sequence svc_high_s;
		SERVICE_N [*4];
	endsequence
	sequence wr_take_s;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	svc_force_a: assert property (
		svc_low_s |-> SER_CFG == SERCFG_SERVICE && SERVICE_MODE && CMD_SET_EN)
		else $error("service setting not forced");
	svc_release_a: assert property (
		svc_high_s |-> !SERVICE_MODE)
		else $error("service mode held after release");
	// The response register follows the edge that merges both halves.
	wr_answer_a: assert property (wr_take_s |=> ##1 S_AXI_BVALID)
		else $error("write response late");
	rd_answer_a: assert property (
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read data late");
	b_retire_a: assert property (
		S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
		else $error("write response repeated");
	wr_refuse_a: assert property (
		S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write taken while response pending");
	rd_refuse_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read taken while data pending");
	reboot_block_a: assert property (
		REBOOT |-> !RADIO_RX_EN && !RADIO_TX_EN)
		else $error("radio enabled at reboot");
	wake_hold_a: assert property (
		WAKE_ACK |-> (run_cnt >= WAKE_CYCLES - 1) ##1 !WAKE_ACK)
		else $error("wake acknowledged too soon");
endmodule // stat_service_chk
bind stat_service stat_service_chk chk_i (
	.SYS_CLK(SYS_CLK),
	.RST_N(RST_N),
	.S_AXI_AWVALID(S_AXI_AWVALID),
	.S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID),
	.S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RVALID(S_AXI_RVALID),
	.SERVICE_N(SERVICE_N),
	.TXD_IN(TXD_IN),
	.SER_CFG(SER_CFG),
	.SERVICE_MODE(SERVICE_MODE),
	.CMD_SET_EN(CMD_SET_EN),
	.RADIO_RX_EN(RADIO_RX_EN),
	.RADIO_TX_EN(RADIO_TX_EN),
	.WAKE_ACK(WAKE_ACK),
	.REBOOT(REBOOT)
);
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the status and service block.
// Assumes the host model drives the service and transmit data pins.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import stat_service_pkg::*;
	localparam int TK = 10;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_t;
	logic clk = 0, rst_n = 0, svc_on = 0, wake_go = 0;
	logic [7:0] awaddr = '0, araddr = '0, fcode = '0;
	logic [31:0] wdata = '0, rdata, cfg, d;
	logic [1:0] bresp, rresp, r;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic sync = 0, frame = 0, txreq = 0, txgo = 0, fault = 0, esc = 0;
	logic awready, wready, bvalid, arready, rvalid, svc_n, txd, stat;
	logic svcm, cmden, rxen, txen, wack, reboot, irq;
	int error_cnt = 0, check_count = 0, n, t0, cyc = 0;
	row_t rows[7] = '{'{CTRL_OFS, '0, '0}, '{SERCFG_OFS, SERCFG_RESET, '0},
		'{STATUS_OFS, 32'h80, '0}, '{FCODE_OFS, '0, '0},
		'{INT_STAT_OFS, '0, '0}, '{INT_EN_OFS, '0, '0}, '{8'h20, '0, 2'h2}};
	// Clock and a cycle count for the long timing checks.
	always #4 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	stat_service #(.TICK_CYCLES(TK)) DUT (.SYS_CLK(clk), .RST_N(rst_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .SERVICE_N(svc_n), .TXD_IN(txd),
		.RF_SYNC_FOUND(sync), .RF_FRAME_ACTIVE(frame), .TX_REQ(txreq),
		.TX_FRAME_START(txgo), .FAULT_EVENT(fault), .FAULT_CODE_IN(fcode),
		.ESCAPE_SEQ(esc), .STAT(stat), .SER_CFG(cfg), .SERVICE_MODE(svcm),
		.CMD_SET_EN(cmden), .RADIO_RX_EN(rxen), .RADIO_TX_EN(txen),
		.WAKE_ACK(wack), .REBOOT(reboot), .IRQ(irq));
	host_model HOST (.clk(clk), .svc_on(svc_on), .wake_go(wake_go),
		.service_n(svc_n), .txd(txd));
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic hang();
		error_cnt++;
		$display("mismatch wait expected done seen timeout");
		complete_run();
	endtask
	// One write; each channel is released at the edge that takes it.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bit aw = 0, w = 0, f = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (int i = 0; i < 50 && !f; i++) begin
			@(posedge clk);
			if (bvalid === 1'b1 && aw && w) begin
				r = bresp;
				f = 1;
				bready <= 0;
			end
			if (awvalid && awready === 1'b1) begin
				aw = 1;
				awvalid <= 0;
			end
			if (wvalid && wready === 1'b1) begin
				w = 1;
				wvalid <= 0;
			end
		end
		if (!f)
			hang();
	endtask
	task automatic rd(input logic [7:0] a);
		bit ar = 0, f = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (int i = 0; i < 50 && !f; i++) begin
			@(posedge clk);
			if (rvalid === 1'b1 && ar) begin
				d = rdata;
				r = rresp;
				f = 1;
				rready <= 0;
			end
			if (arvalid && arready === 1'b1) begin
				ar = 1;
				arvalid <= 0;
			end
		end
		if (!f)
			hang();
	endtask
	// Cycles between two status changes; the first change may be partial.
	task automatic gap(input int e);
		logic s;
		int c = 0;
		@(posedge clk);
		s = stat;
		while (stat === s && c < 30000) begin
			@(posedge clk);
			c++;
		end
		if (stat === s)
			hang();
		s = stat;
		c = 0;
		while (stat === s && c < 30000) begin
			@(posedge clk);
			c++;
		end
		if (stat === s)
			hang();
		chk("toggle gap", e, c);
	endtask
	// Reset, the register table, then the hand-written cases.
	initial begin
		repeat (3) @(posedge clk);
		chk("reset status pin", 1, stat);
		rst_n <= 1;
		foreach (rows[i]) begin
			rd(rows[i].a);
			chk("register value", rows[i].d, d);
			chk("register resp", rows[i].r, r);
		end
		wr(SERCFG_OFS, 32'h0081_c200);
		wr(INT_EN_OFS, 32'h8);
		svc_on <= 1;
		repeat (6) @(posedge clk);
		chk("service config", SERCFG_SERVICE, cfg);
		chk("service commands", 1, cmden);
		chk("service flag", 1, svcm);
		rd(SERCFG_OFS);
		chk("stored config", 32'h0081_c200, d);
		svc_on <= 0;
		repeat (6) @(posedge clk);
		chk("config back", 32'h0081_c200, cfg);
		chk("commands back", 0, cmden);
		wr(INT_EN_OFS, '0);
		chk("irq masked", 0, irq);
		wr(INT_EN_OFS, 32'h8);
		chk("irq raised", 1, irq);
		wr(INT_CLR_OFS, 32'h8);
		chk("irq cleared", 0, irq);
		wr(STATUS_OFS, '0);
		chk("read-only resp", 2, r);
		sync <= 1;
		@(posedge clk);
		sync <= 0;
		rd(STATUS_OFS);
		chk("receive mode", 1, d[2:0]);
		frame <= 1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 20; i++) begin
			chk("frame status", 0, stat);
			@(posedge clk);
		end
		frame <= 0;
		repeat (3) @(posedge clk);
		chk("idle status", 1, stat);
		txreq <= 1;
		repeat (3) @(posedge clk);
		chk("transmit enable", 1, txen);
		for (int i = 0; i < 2; i++) begin
			d[0] = stat;
			txgo <= 1;
			@(posedge clk);
			txgo <= 0;
			repeat (3) @(posedge clk);
			chk("transmit toggle", {31'h0, ~d[0]}, stat);
		end
		txreq <= 0;
		wr(CTRL_OFS, 32'h2);
		gap(1000 * TK);
		esc <= 1;
		@(posedge clk);
		esc <= 0;
		repeat (3) @(posedge clk);
		chk("escape commands", 1, cmden);
		gap(500 * TK);
		wr(CTRL_OFS, 32'h20);
		wr(CTRL_OFS, 32'h4);
		repeat (3) @(posedge clk);
		chk("sleep status", 0, stat);
		chk("sleep receiver", 0, rxen);
		wake_go <= 1;
		n = 0;
		while (wack !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (wack !== 1'b1)
			hang();
		chk("wake delay", 1, n >= WAKE_CYCLES);
		wake_go <= 0;
		repeat (3) @(posedge clk);
		chk("awake receiver", 1, rxen);
		// Five frames 100 ms apart finish the study; sleep follows the last.
		wr(CTRL_OFS, 32'h8);
		for (int i = 0; i < 5; i++) begin
			frame <= 1;
			repeat (10 * TK) @(posedge clk);
			frame <= 0;
			repeat (i < 4 ? 90 * TK : 3) @(posedge clk);
		end
		chk("power save sleep", 0, rxen);
		repeat (30 * TK) @(posedge clk);
		chk("power save wake", 1, rxen);
		fcode <= 8'h5a;
		fault <= 1;
		t0 = cyc;
		@(posedge clk);
		fault <= 0;
		repeat (3) @(posedge clk);
		chk("fault blocks rx", 0, rxen);
		gap(250 * TK);
		rd(FCODE_OFS);
		chk("fault code", 32'h5a, d);
		while (reboot !== 1'b1 && cyc - t0 < 60000)
			@(posedge clk);
		if (reboot !== 1'b1)
			hang();
		// The tick phase at the fault is free, so allow one tick of slack.
		n = cyc - t0 - 3;
		chk("reboot time", 1, n > 4999 * TK && n <= 5000 * TK);
		rd(STATUS_OFS);
		chk("safe mode", 4, d[2:0]);
		rd(FCODE_OFS);
		chk("safe fault code", 32'h5a, d);
		wr(CTRL_OFS, 32'h10);
		rd(STATUS_OFS);
		chk("restart mode", 0, d[2:0]);
		complete_run();
	end
endmodule // testbench
`default_nettype wire
